// ---- logic/event_record_code_encoder.sv ----
`timescale 1ns/1ps
// Contract
// - distortion under-trigger sub 39..43, value x10000
// - odd current distortion under sub 44, x1000
// - demand power under subs 45..47, x1000
// - current demand under sub 48, x100
// - voltage/current returns subs 49..51 scaled
// - power returns subs 52,53 unscaled
// - power factor return sub 54, x1000
// - distortion returns subs 55..59, x10000
// - odd current distortion return 60, x1000
// - demand returns 61..63 x1000, 64 x100
// - sub 65 bit31 output closed/open
// - sub 65 bits16..30 input number 1..6
// - sub 65 bits0,1 outputs; 2..15 zero
// - class 4 value 0; subs 1..4
// - counter clear logs class 4 sub 5
// - log clear: sub 6 buttons, 7 link
// - energy clear: sub 8 buttons, 9 link
// - peak demand clear: subs 10, 11
// - max/min log clear: subs 12, 13
module event_record_code_encoder (
    input  wire logic                                    sys_clk,
    input  wire logic                                    reset,
    input  wire logic                                    underValid,
    input  wire logic [3:0]                              underKind,
    input  wire logic [31:0]                             underValue,
    output      logic                                    underReady,
    input  wire logic                                    returnValid,
    input  wire logic [3:0]                              returnKind,
    input  wire logic [31:0]                             returnValue,
    output      logic                                    returnReady,
    input  wire logic                                    linkValid,
    input  wire logic [2:0]                              linkInput,
    input  wire logic [1:0]                              linkOutputs,
    input  wire logic                                    linkClosed,
    output      logic                                    linkReady,
    input  wire logic [event_record_pkg::SYS_EVENTS-1:0] systemEvent,
    output      logic [event_record_pkg::SYS_EVENTS-1:0] systemPending,
    output      logic                                    recValid,
    output      logic [7:0]                              recClass,
    output      logic [7:0]                              recSubClass,
    output      logic [31:0]                             recValue,
    output      logic                                    recSaturated,
    output      logic                                    reqRejected
);
    import event_record_pkg::*;

    // ------------------------------------------------------------
    // held requests
    // ------------------------------------------------------------
    logic                  pendUnder_r;
    logic [3:0]            underKind_r;
    logic [31:0]           underVal_r;
    logic                  pendReturn_r;
    logic [3:0]            returnKind_r;
    logic [31:0]           returnVal_r;
    logic                  pendLink_r;
    logic [2:0]            linkInput_r;
    logic [1:0]            linkOutputs_r;
    logic                  linkClosed_r;
    logic [SYS_EVENTS-1:0] sysPend_r;
    logic [SYS_EVENTS-1:0] sysPend_nxt;
    logic                  underReady_r;
    logic                  returnReady_r;
    logic                  linkReady_r;
    logic                  recValid_r;
    logic [7:0]            recClass_r;
    logic [7:0]            recSubClass_r;
    logic [31:0]           recValue_r;
    logic                  recSaturated_r;
    logic                  reqRejected_r;

    // ------------------------------------------------------------
    // acceptance decode
    // ------------------------------------------------------------
    logic underLegal;
    logic linkLegal;
    logic underTake;
    logic returnTake;
    logic linkTake;
    logic rejectNxt;

    assign underLegal = underKind < 4'(UNDER_KINDS);
    assign linkLegal  = linkInput >= DI_FIRST && linkInput <= DI_LAST;
    assign underTake  = underValid && underReady_r && underLegal;
    assign returnTake = returnValid && returnReady_r;
    assign linkTake   = linkValid && linkReady_r && linkLegal;
    assign rejectNxt  = (underValid && underReady_r && !underLegal) ||
                        (linkValid && linkReady_r && !linkLegal);

    // ------------------------------------------------------------
    // fixed-priority pick: system, link, return, under
    // ------------------------------------------------------------
    logic                  sysAny;
    logic                  grantLink;
    logic                  grantReturn;
    logic                  grantUnder;
    logic                  grantAny;
    logic [SYS_EVENTS-1:0] sysGrant;
    logic [SYS_EVENTS:0]   sysBelow;
    logic [7:0]            sysSubChain [SYS_EVENTS+1];

    assign sysBelow[0]    = 1'b0;
    assign sysSubChain[0] = SUB_NONE;

    genvar i;
    generate
        for (i = 0; i < SYS_EVENTS; i++) begin : g_sys
            assign sysGrant[i]      = sysPend_r[i] && !sysBelow[i];
            assign sysBelow[i+1]    = sysBelow[i] || sysPend_r[i];
            assign sysSubChain[i+1] = sysSubChain[i] |
                                      (sysGrant[i] ? SUB_SYS_BASE + 8'(i) : SUB_NONE);
            assign sysPend_nxt[i]   = systemEvent[i] || (sysPend_r[i] && !sysGrant[i]);
        end
    endgenerate

    assign sysAny      = sysBelow[SYS_EVENTS];
    assign grantLink   = pendLink_r && !sysAny;
    assign grantReturn = pendReturn_r && !sysAny && !pendLink_r;
    assign grantUnder  = pendUnder_r && !sysAny && !pendLink_r && !pendReturn_r;
    assign grantAny    = sysAny || pendLink_r || pendReturn_r || pendUnder_r;

    // ------------------------------------------------------------
    // value builders
    // ------------------------------------------------------------
    event_value_if underBus ();
    event_value_if returnBus ();
    logic [31:0]   linkValue;

    assign underBus.raw    = underVal_r;
    assign underBus.scale  = underScale(underKind_r);
    assign returnBus.raw   = returnVal_r;
    assign returnBus.scale = returnScale(returnKind_r);

    event_value_scaler underScaler (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (underBus.server)
    );

    event_value_scaler returnScaler (
        .sys_clk (sys_clk),
        .reset   (reset),
        .bus     (returnBus.server)
    );

    dio_value_packer linkPacker (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .closed   (linkClosed_r),
        .inputNum (linkInput_r),
        .outputs  (linkOutputs_r),
        .value    (linkValue)
    );

    // ------------------------------------------------------------
    // record select
    // ------------------------------------------------------------
    logic [7:0]  classNxt;
    logic [7:0]  subNxt;
    logic [31:0] valueNxt;
    logic        satNxt;

    assign classNxt = sysAny ? CLASS_SYSTEM : CLASS_SETPOINT;
    assign subNxt   = sysAny      ? sysSubChain[SYS_EVENTS] :
                      grantLink   ? SUB_DIO_LINK :
                      grantReturn ? SUB_RETURN_BASE + 8'(returnKind_r) :
                                    SUB_UNDER_BASE + 8'(underKind_r);
    assign valueNxt = sysAny      ? 32'h00000000 :
                      grantLink   ? linkValue :
                      grantReturn ? returnBus.scaled : underBus.scaled;
    assign satNxt   = grantReturn ? returnBus.saturated :
                      grantUnder  ? underBus.saturated : 1'b0;

    // ------------------------------------------------------------
    // request holding
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendUnder_r  <= 1'b0;
            underKind_r  <= 4'h0;
            underVal_r   <= 32'h00000000;
            underReady_r <= 1'b0;
        end else begin
            pendUnder_r  <= underTake || (pendUnder_r && !grantUnder);
            underReady_r <= !(underTake || (pendUnder_r && !grantUnder));
            if (underTake) begin
                underKind_r <= underKind;
                underVal_r  <= underValue;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendReturn_r  <= 1'b0;
            returnKind_r  <= 4'h0;
            returnVal_r   <= 32'h00000000;
            returnReady_r <= 1'b0;
        end else begin
            pendReturn_r  <= returnTake || (pendReturn_r && !grantReturn);
            returnReady_r <= !(returnTake || (pendReturn_r && !grantReturn));
            if (returnTake) begin
                returnKind_r <= returnKind;
                returnVal_r  <= returnValue;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendLink_r    <= 1'b0;
            linkInput_r   <= 3'h0;
            linkOutputs_r <= 2'h0;
            linkClosed_r  <= 1'b0;
            linkReady_r   <= 1'b0;
        end else begin
            pendLink_r  <= linkTake || (pendLink_r && !grantLink);
            linkReady_r <= !(linkTake || (pendLink_r && !grantLink));
            if (linkTake) begin
                linkInput_r   <= linkInput;
                linkOutputs_r <= linkOutputs;
                linkClosed_r  <= linkClosed;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            sysPend_r <= '0;
        else
            sysPend_r <= sysPend_nxt;
    end

    // ------------------------------------------------------------
    // record output
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            recValid_r     <= 1'b0;
            recClass_r     <= 8'h00;
            recSubClass_r  <= 8'h00;
            recValue_r     <= 32'h00000000;
            recSaturated_r <= 1'b0;
            reqRejected_r  <= 1'b0;
        end else begin
            recValid_r    <= grantAny;
            reqRejected_r <= rejectNxt;
            if (grantAny) begin
                recClass_r     <= classNxt;
                recSubClass_r  <= subNxt;
                recValue_r     <= valueNxt;
                recSaturated_r <= satNxt;
            end
        end
    end

    assign underReady    = underReady_r;
    assign returnReady   = returnReady_r;
    assign linkReady     = linkReady_r;
    assign systemPending = sysPend_r;
    assign recValid      = recValid_r;
    assign recClass      = recClass_r;
    assign recSubClass   = recSubClass_r;
    assign recValue      = recValue_r;
    assign recSaturated  = recSaturated_r;
    assign reqRejected   = reqRejected_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence underAlone;
        underTake && !pendReturn_r && !pendLink_r && sysPend_r == '0 &&
            systemEvent == '0 && !returnTake && !linkTake;
    endsequence
    sequence underPicked;
        grantUnder && systemEvent == '0 && !returnTake && !linkTake;
    endsequence

    under_latency_a: assert property (underAlone ##1 underPicked |=>
            recValid_r && recClass_r == CLASS_SETPOINT &&
            recSubClass_r == SUB_UNDER_BASE + 8'($past(underKind, 2)))
        else $error("under record missing or miscoded");
    under_scale_a: assert property (grantUnder && underKind_r == 4'h9 && !underBus.saturated |=>
            recSubClass_r == 8'h30 && recValue_r == 32'($past(underVal_r) * 32'h64))
        else $error("current demand under value wrong");
    return_sub_a: assert property (grantReturn |=>
            recSubClass_r >= 8'h31 && recSubClass_r <= 8'h40 &&
            recSubClass_r == SUB_RETURN_BASE + 8'($past(returnKind_r)))
        else $error("return sub-code wrong");
    return_plain_a: assert property (grantReturn && (returnKind_r == 4'h3 || returnKind_r == 4'h4) |=>
            recValue_r == $past(returnVal_r))
        else $error("power return value scaled");
    link_value_a: assert property (grantLink |=> recSubClass_r == SUB_DIO_LINK &&
            recValue_r[31] == $past(linkClosed_r) && recValue_r[18:16] == $past(linkInput_r) &&
            recValue_r[1:0] == $past(linkOutputs_r))
        else $error("link record value wrong");
    sys_record_a: assert property (sysAny |=> recValid_r && recClass_r == CLASS_SYSTEM &&
            recValue_r == 32'h00000000 && recSubClass_r >= 8'h01 && recSubClass_r <= 8'h0D)
        else $error("system record wrong");
    sys_setwins_a: assert property (systemEvent[4] |=> sysPend_r[4])
        else $error("system event lost");
    sys_first_a: assert property (sysPend_r[6:0] == 7'h60 && systemEvent[5:0] == 6'h00 |=>
            recSubClass_r == 8'h06 ##1 recSubClass_r == 8'h07)
        else $error("log clear records out of order");
    one_record_a: assert property (grantAny ##1 !grantAny |=> !recValid_r)
        else $error("extra record emitted");
    no_reserved_a: assert property (recValid_r |->
            (recClass_r == CLASS_SETPOINT && recSubClass_r >= 8'h27 && recSubClass_r <= 8'h41) ||
            (recClass_r == CLASS_SYSTEM && recSubClass_r >= 8'h01 && recSubClass_r <= 8'h0D))
        else $error("reserved code emitted");

endmodule

// ---- logic/event_record_pkg.sv ----
package event_record_pkg;

    // ------------------------------------------------------------
    // record classes and sub-code bases
    // ------------------------------------------------------------
    localparam logic [7:0] CLASS_SETPOINT  = 8'h03;
    localparam logic [7:0] CLASS_SYSTEM    = 8'h04;
    localparam logic [7:0] SUB_UNDER_BASE  = 8'h27;
    localparam logic [7:0] SUB_RETURN_BASE = 8'h31;
    localparam logic [7:0] SUB_DIO_LINK    = 8'h41;
    localparam logic [7:0] SUB_SYS_BASE    = 8'h01;
    localparam logic [7:0] SUB_NONE        = 8'h00;

    // ------------------------------------------------------------
    // source counts
    // ------------------------------------------------------------
    localparam int         UNDER_KINDS  = 10;
    localparam int         RETURN_KINDS = 16;
    localparam int         SYS_EVENTS   = 13;
    localparam logic [2:0] DI_FIRST     = 3'h1;
    localparam logic [2:0] DI_LAST      = 3'h6;

    // ------------------------------------------------------------
    // linked input/output value layout
    // ------------------------------------------------------------
    localparam int DIO_CLOSED_BIT = 31;
    localparam int DIO_INPUT_MSB  = 30;
    localparam int DIO_INPUT_LSB  = 16;
    localparam int DIO_OUT2_BIT   = 1;
    localparam int DIO_OUT1_BIT   = 0;

    // ------------------------------------------------------------
    // scaling
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCALE_X1     = 2'b00,
        SCALE_X100   = 2'b01,
        SCALE_X1000  = 2'b10,
        SCALE_X10000 = 2'b11
    } scale_e;

    localparam logic [13:0] FACTOR_1     = 14'h0001;
    localparam logic [13:0] FACTOR_100   = 14'h0064;
    localparam logic [13:0] FACTOR_1000  = 14'h03E8;
    localparam logic [13:0] FACTOR_10000 = 14'h2710;

    // kind 0..9 maps to sub-codes 39..48
    function automatic scale_e underScale(input logic [3:0] kind);
        scale_e s;
        s = SCALE_X10000;
        if (kind >= 4'h5 && kind <= 4'h8)
            s = SCALE_X1000;
        else if (kind == 4'h9)
            s = SCALE_X100;
        return s;
    endfunction

    // kind 0..15 maps to sub-codes 49..64
    function automatic scale_e returnScale(input logic [3:0] kind);
        scale_e s;
        unique case (kind)
            4'h0, 4'h1, 4'hF:             s = SCALE_X100;
            4'h3, 4'h4:                   s = SCALE_X1;
            4'h6, 4'h7, 4'h8, 4'h9, 4'hA: s = SCALE_X10000;
            default:                      s = SCALE_X1000;
        endcase
        return s;
    endfunction

endpackage

// ---- logic/event_value_if.sv ----
`timescale 1ns/1ps
interface event_value_if;
    import event_record_pkg::*;
    logic [31:0] raw;
    scale_e      scale;
    logic [31:0] scaled;
    logic        saturated;
    modport client (output raw, output scale, input scaled, input saturated);
    modport server (input raw, input scale, output scaled, output saturated);
endinterface

// ---- logic/event_value_scaler.sv ----
`timescale 1ns/1ps
module event_value_scaler (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    event_value_if.server    bus
);
    import event_record_pkg::*;

    // ------------------------------------------------------------
    // factor select and saturating product
    // ------------------------------------------------------------
    logic [13:0] factor;
    logic [45:0] product;

    assign factor = (bus.scale == SCALE_X100)   ? FACTOR_100 :
                    (bus.scale == SCALE_X1000)  ? FACTOR_1000 :
                    (bus.scale == SCALE_X10000) ? FACTOR_10000 : FACTOR_1;
    assign product       = 46'(bus.raw) * 46'(factor);
    assign bus.saturated = |product[45:32];
    assign bus.scaled    = bus.saturated ? 32'hFFFFFFFF : product[31:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    scale_value_a: assert property (@(posedge sys_clk) disable iff (reset)
        !bus.saturated |-> 64'(bus.scaled) ==
            64'(bus.raw) * ((bus.scale == SCALE_X1)    ? 64'h1 :
                            (bus.scale == SCALE_X100)  ? 64'h64 :
                            (bus.scale == SCALE_X1000) ? 64'h3E8 : 64'h2710))
        else $error("scaled value does not match factor");
    unscaled_pass_a: assert property (@(posedge sys_clk) disable iff (reset)
        bus.scale == SCALE_X1 |-> bus.scaled == bus.raw && !bus.saturated)
        else $error("unscaled value altered");

endmodule

// ---- logic/dio_value_packer.sv ----
`timescale 1ns/1ps
module dio_value_packer (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        closed,
    input  wire logic [2:0]  inputNum,
    input  wire logic [1:0]  outputs,
    output      logic [31:0] value
);
    import event_record_pkg::*;

    always_comb begin
        value = 32'h00000000;
        value[DIO_CLOSED_BIT] = closed;
        value[DIO_INPUT_MSB:DIO_INPUT_LSB] = 15'(inputNum);
        value[DIO_OUT2_BIT:DIO_OUT1_BIT] = outputs;
    end

    dio_reserved_a: assert property (@(posedge sys_clk) disable iff (reset)
        value[15:2] == 14'h0000 && value[DIO_INPUT_MSB:DIO_INPUT_LSB] <= 15'h0007)
        else $error("reserved link value bits set");

endmodule

// ---- verification/event_record_code_encoder_tb_top.sv ----
`timescale 1ns/1ps
module event_record_code_encoder_tb_top;
    import event_record_pkg::*;

    logic                  sys_clk;
    logic                  reset;
    logic                  underValid, returnValid, linkValid, linkClosed;
    logic [3:0]            underKind, returnKind;
    logic [31:0]           underValue, returnValue, v;
    logic [2:0]            linkInput;
    logic [1:0]            linkOutputs;
    logic [SYS_EVENTS-1:0] systemEvent, systemPending;
    logic                  underReady, returnReady, linkReady, recValid, recSaturated, reqRejected;
    logic [7:0]            recClass, recSubClass;
    logic [31:0]           recValue;
    int                    errorCnt, checked, k, j;

    event_record_code_encoder dut_u (.sys_clk(sys_clk), .reset(reset), .underValid(underValid),
        .underKind(underKind), .underValue(underValue), .underReady(underReady),
        .returnValid(returnValid), .returnKind(returnKind), .returnValue(returnValue),
        .returnReady(returnReady), .linkValid(linkValid), .linkInput(linkInput),
        .linkOutputs(linkOutputs), .linkClosed(linkClosed), .linkReady(linkReady),
        .systemEvent(systemEvent), .systemPending(systemPending), .recValid(recValid),
        .recClass(recClass), .recSubClass(recSubClass), .recValue(recValue),
        .recSaturated(recSaturated), .reqRejected(reqRejected));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] factor(input logic ret, input logic [3:0] kd);
        if (!ret)
            return (kd < 4'h5) ? 32'h0000_2710 : (kd < 4'h9) ? 32'h0000_03E8 : 32'h0000_0064;
        case (kd)
            4'h0, 4'h1, 4'hF:             return 32'h0000_0064;
            4'h3, 4'h4:                   return 32'h0000_0001;
            4'h6, 4'h7, 4'h8, 4'h9, 4'hA: return 32'h0000_2710;
            default:                      return 32'h0000_03E8;
        endcase
    endfunction

    // saturates when the product no longer fits 32 bits
    function automatic logic [31:0] scaled(input logic [31:0] f, input logic [31:0] raw);
        logic [63:0] p;
        p = {32'h0000_0000, f} * {32'h0000_0000, raw};
        return (p > 64'h0000_0000_FFFF_FFFF) ? 32'hFFFF_FFFF : p[31:0];
    endfunction

    function automatic logic sel(input int ch);
        case (ch)
            0:       return underReady;
            1:       return returnReady;
            2:       return linkReady;
            3:       return recValid;
            default: return reqRejected;
        endcase
    endfunction

    task automatic waitSig(input int ch);
        int n;
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (sel(ch) === 1'b1)
                break;
        end
        if (n == 40) begin
            errorCnt++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
            wrapUp();
        end
    endtask

    // ------------------------------------------------------------
    // request drivers
    // ------------------------------------------------------------
    task automatic offer(input int ch, input logic [3:0] kd, input logic [31:0] raw,
                         input logic [2:0] inp, input logic [1:0] outs, input logic cl);
        waitSig(ch);
        @(posedge sys_clk);
        case (ch)
            0: begin
                underValid <= 1'b1;
                underKind  <= kd;
                underValue <= raw;
            end
            1: begin
                returnValid <= 1'b1;
                returnKind  <= kd;
                returnValue <= raw;
            end
            default: begin
                linkValid   <= 1'b1;
                linkInput   <= inp;
                linkOutputs <= outs;
                linkClosed  <= cl;
            end
        endcase
        @(posedge sys_clk);
        underValid  <= 1'b0;
        returnValid <= 1'b0;
        linkValid   <= 1'b0;
    endtask

    task automatic expectRec(input logic [7:0] c, input logic [7:0] s, input logic [31:0] val);
        waitSig(3);
        chk(recClass, c);
        chk(recSubClass, s);
        chk(recValue, val);
        chk(recSaturated, val == 32'hFFFF_FFFF);
    endtask

    task automatic expectReject();
        waitSig(4);
        chk(reqRejected, 1'b1);
        repeat (4) begin
            @(negedge sys_clk);
            chk(recValid, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {underValid, returnValid, linkValid, linkClosed} = 4'h0;
        {underKind, returnKind, linkInput, linkOutputs} = 13'h0000;
        {underValue, returnValue} = 64'h0;
        systemEvent = '0;
        reset = 1'b1;
        errorCnt = 0;
        checked = 0;
        v = $urandom(32'h8FC37B4A);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (j = 0; j < 2; j++) begin
            for (k = 0; k < 10; k++) begin
                v = $urandom % 32'h0006_1A80;
                offer(0, k[3:0], v, 3'h0, 2'h0, 1'b0);
                expectRec(8'h03, 8'h27 + k[7:0], scaled(factor(1'b0, k[3:0]), v));
            end
            for (k = 0; k < 16; k++) begin
                v = $urandom % 32'h0006_1A80;
                offer(1, k[3:0], v, 3'h0, 2'h0, 1'b0);
                expectRec(8'h03, 8'h31 + k[7:0], scaled(factor(1'b1, k[3:0]), v));
            end
        end
        offer(0, 4'h0, 32'hFFFF_FFFF, 3'h0, 2'h0, 1'b0);
        expectRec(8'h03, 8'h27, 32'hFFFF_FFFF);
        chk(recSaturated, 1'b1);
        for (k = 0; k < 8; k++) begin
            v = $urandom;
            offer(2, 4'h0, 32'h0, k[2:0], v[1:0], v[2]);
            if (k >= 1 && k <= 6)
                expectRec(8'h03, 8'h41, {v[2], 12'h000, k[2:0], 14'h0000, v[1:0]});
            else
                expectReject();
        end
        for (k = 10; k < 16; k++) begin
            offer(0, k[3:0], $urandom, 3'h0, 2'h0, 1'b0);
            expectReject();
        end
        @(posedge sys_clk);
        systemEvent <= '1;
        @(posedge sys_clk);
        systemEvent <= '0;
        @(negedge sys_clk);
        chk(systemPending, 13'h1FFF);
        for (k = 0; k < 13; k++)
            expectRec(8'h04, 8'h01 + k[7:0], 32'h0000_0000);
        repeat (4) begin
            @(negedge sys_clk);
            chk(recValid, 1'b0);
        end
        wrapUp();
    end
endmodule
